// ### include/ddr2_ctl_pkg.sv
// Constants and types for the control-input stage
package ddr2_ctl_pkg;
  localparam int DQ_W = 16;
  localparam int TERM_W = 22;
  localparam logic [3:0] CMD_NOP = 4'h7;
  localparam logic [3:0] CMD_DESEL = 4'h8;
  localparam logic [3:0] CMD_REF = 4'h1;
  localparam logic [3:0] CMD_PRE = 4'h2;
  localparam logic [3:0] CMD_ACT = 4'h3;
  localparam logic [3:0] CMD_WR = 4'h4;
  localparam logic [3:0] CMD_RD = 4'h5;
  localparam logic [3:0] CMD_MRS = 4'h0;
  localparam logic [2:0] BANKS = 3'h4;
  typedef enum logic [3:0] {
    ST_ACTIVE = 4'h1,
    ST_PRE_PD = 4'h2,
    ST_ACT_PD = 4'h4,
    ST_SELF = 4'h8
  } pwr_t;
  typedef enum logic [3:0] {
    CD_NOP = 4'h1,
    CD_ACT = 4'h2,
    CD_PRE = 4'h4,
    CD_OTHER = 4'h8
  } cmd_t;
endpackage : ddr2_ctl_pkg

// ### rtl/cmd_decode.sv
// Command decoder from chip select and strobes
`timescale 1ns/1ps
module cmd_decode (
  input wire logic csN,
  input wire logic rasN,
  input wire logic casN,
  input wire logic weN,
  output ddr2_ctl_pkg::cmd_t cmdKind
);
  logic [3:0] code;
  always_comb begin
    code = {csN, rasN, casN, weN};
    if (code[3]) begin
      cmdKind = ddr2_ctl_pkg::CD_NOP;
    end else if (code == ddr2_ctl_pkg::CMD_ACT) begin
      cmdKind = ddr2_ctl_pkg::CD_ACT;
    end else if (code == ddr2_ctl_pkg::CMD_PRE) begin
      cmdKind = ddr2_ctl_pkg::CD_PRE;
    end else if (code == ddr2_ctl_pkg::CMD_NOP) begin
      cmdKind = ddr2_ctl_pkg::CD_NOP;
    end else begin
      cmdKind = ddr2_ctl_pkg::CD_OTHER;
    end
  end
endmodule : cmd_decode

// ### rtl/sync2.sv
// Two-flop synchroniser
`timescale 1ns/1ps
module sync2 (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic din,
  output logic dout
);
  logic meta_r;
  logic meta_nxt;
  logic dout_nxt;
  always_comb begin
    meta_nxt = din;
    dout_nxt = meta_r;
  end
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      meta_r <= 1'b0;
      dout <= 1'b0;
    end else begin
      meta_r <= meta_nxt;
      dout <= dout_nxt;
    end
  end
endmodule : sync2

// ### rtl/ddr2_control_input_stage.sv
// Control-input stage: clock edges, power states, command and termination
`timescale 1ns/1ps
module ddr2_control_input_stage (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic ck,
  input wire logic cke,
  input wire logic csN,
  input wire logic rasN,
  input wire logic casN,
  input wire logic weN,
  input wire logic [1:0] bankAddr,
  input wire logic odt,
  input wire logic odtDisabled,
  input wire logic refreshReq,
  input wire logic [ddr2_ctl_pkg::DQ_W-1:0] rdDataRise,
  input wire logic [ddr2_ctl_pkg::DQ_W-1:0] rdDataFall,
  output logic [ddr2_ctl_pkg::DQ_W-1:0] dqOut,
  output logic dqOutStrobe,
  output logic [3:0] cmdCode,
  output logic cmdValid,
  output logic [1:0] cmdBank,
  output logic intClkEn,
  output logic inBufEn,
  output logic outDrvEn,
  output logic ckBufEn,
  output logic odtBufEn,
  output logic [ddr2_ctl_pkg::TERM_W-1:0] termEn,
  output ddr2_ctl_pkg::pwr_t pwrState
);
  // Sampled pins; every pin passes two flops before any logic reads it
  logic ckS;
  logic ckeS;
  logic csS;
  logic rasS;
  logic casS;
  logic weS;
  logic odtS;
  logic [1:0] baS;
  sync2 uCk (.clk_sys(clk_sys), .rst_n(rst_n), .din(ck), .dout(ckS));
  sync2 uCke (.clk_sys(clk_sys), .rst_n(rst_n), .din(cke), .dout(ckeS));
  sync2 uCs (.clk_sys(clk_sys), .rst_n(rst_n), .din(csN), .dout(csS));
  sync2 uRas (.clk_sys(clk_sys), .rst_n(rst_n), .din(rasN), .dout(rasS));
  sync2 uCas (.clk_sys(clk_sys), .rst_n(rst_n), .din(casN), .dout(casS));
  sync2 uWe (.clk_sys(clk_sys), .rst_n(rst_n), .din(weN), .dout(weS));
  sync2 uOdt (.clk_sys(clk_sys), .rst_n(rst_n), .din(odt), .dout(odtS));
  sync2 uBa0 (.clk_sys(clk_sys), .rst_n(rst_n), .din(bankAddr[0]), .dout(baS[0]));
  sync2 uBa1 (.clk_sys(clk_sys), .rst_n(rst_n), .din(bankAddr[1]), .dout(baS[1]));

  logic ckPrev_r;
  logic ckPrev_nxt;
  logic ckRise;
  logic ckFall;
  assign ckRise = ckS && !ckPrev_r;
  assign ckFall = !ckS && ckPrev_r;

  ddr2_ctl_pkg::cmd_t cmdKind;
  cmd_decode uDec (.csN(csS), .rasN(rasS), .casN(casS), .weN(weS), .cmdKind(cmdKind));

  ddr2_ctl_pkg::pwr_t pwr_r;
  ddr2_ctl_pkg::pwr_t pwr_nxt;
  logic [3:0] openRows_r;
  logic [3:0] openRows_nxt;
  logic [3:0] cmdCode_r;
  logic [3:0] cmdCode_nxt;
  logic cmdValid_r;
  logic cmdValid_nxt;
  logic [1:0] cmdBank_r;
  logic [1:0] cmdBank_nxt;
  logic odtOn_r;
  logic odtOn_nxt;
  logic [ddr2_ctl_pkg::DQ_W-1:0] dq_r;
  logic [ddr2_ctl_pkg::DQ_W-1:0] dq_nxt;
  logic dqs_r;
  logic dqs_nxt;
  logic awake;
  logic ckeLive;

  // Shared state tests for next-state, enable and check logic
  function automatic logic isRunning(input ddr2_ctl_pkg::pwr_t st, input logic en);
    return (st == ddr2_ctl_pkg::ST_ACTIVE) && en;
  endfunction : isRunning

  function automatic logic inSelf(input ddr2_ctl_pkg::pwr_t st);
    return st == ddr2_ctl_pkg::ST_SELF;
  endfunction : inSelf

  function automatic logic inPowerDown(input ddr2_ctl_pkg::pwr_t st);
    return (st == ddr2_ctl_pkg::ST_PRE_PD) || (st == ddr2_ctl_pkg::ST_ACT_PD);
  endfunction : inPowerDown

  // Self refresh exit waits only for the synchronised enable, never for ck
  always_comb begin
    awake = (pwr_r == ddr2_ctl_pkg::ST_ACTIVE);
    ckeLive = ckeS;
  end

  always_comb begin
    ckPrev_nxt = ckS;
    pwr_nxt = pwr_r;
    openRows_nxt = openRows_r;
    cmdCode_nxt = cmdCode_r;
    cmdValid_nxt = 1'b0;
    cmdBank_nxt = cmdBank_r;
    odtOn_nxt = odtOn_r;
    dq_nxt = dq_r;
    dqs_nxt = dqs_r;
    case (pwr_r)
      ddr2_ctl_pkg::ST_ACTIVE: begin
        if (ckRise && !ckeLive) begin
          if (openRows_r != 4'h0) begin
            pwr_nxt = ddr2_ctl_pkg::ST_ACT_PD;
          end else if (refreshReq) begin
            pwr_nxt = ddr2_ctl_pkg::ST_SELF;
          end else begin
            pwr_nxt = ddr2_ctl_pkg::ST_PRE_PD;
          end
        end
      end
      ddr2_ctl_pkg::ST_PRE_PD, ddr2_ctl_pkg::ST_ACT_PD: begin
        if (ckRise && ckeLive) begin
          pwr_nxt = ddr2_ctl_pkg::ST_ACTIVE;
        end
      end
      ddr2_ctl_pkg::ST_SELF: begin
        if (ckeLive) begin
          pwr_nxt = ddr2_ctl_pkg::ST_ACTIVE;
        end
      end
      default: pwr_nxt = ddr2_ctl_pkg::ST_ACTIVE;
    endcase
    if (ckRise && isRunning(pwr_r, ckeLive)) begin
      cmdValid_nxt = !csS;
      cmdCode_nxt = {rasS, casS, weS, 1'b0} >> 1;
      cmdBank_nxt = baS;
      if (cmdKind == ddr2_ctl_pkg::CD_ACT) begin
        openRows_nxt[baS] = 1'b1;
      end else if (cmdKind == ddr2_ctl_pkg::CD_PRE) begin
        openRows_nxt[baS] = 1'b0;
      end
    end
    if (ckRise && !inSelf(pwr_r)) begin
      odtOn_nxt = odtS && !odtDisabled;
    end
    // Disabled termination stays off, even across self refresh
    if (odtDisabled) begin
      odtOn_nxt = 1'b0;
    end
    if (isRunning(pwr_r, ckeLive) && (ckRise || ckFall)) begin
      dq_nxt = ckRise ? rdDataRise : rdDataFall;
      dqs_nxt = ckRise;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ckPrev_r <= 1'b0;
      pwr_r <= ddr2_ctl_pkg::ST_ACTIVE;
      openRows_r <= 4'h0;
      cmdCode_r <= ddr2_ctl_pkg::CMD_NOP;
      cmdValid_r <= 1'b0;
      cmdBank_r <= 2'h0;
      odtOn_r <= 1'b0;
      dq_r <= '0;
      dqs_r <= 1'b0;
    end else begin
      ckPrev_r <= ckPrev_nxt;
      pwr_r <= pwr_nxt;
      openRows_r <= openRows_nxt;
      cmdCode_r <= cmdCode_nxt;
      cmdValid_r <= cmdValid_nxt;
      cmdBank_r <= cmdBank_nxt;
      odtOn_r <= odtOn_nxt;
      dq_r <= dq_nxt;
      dqs_r <= dqs_nxt;
    end
  end

  always_comb begin
    intClkEn = isRunning(pwr_r, ckeLive);
    inBufEn = isRunning(pwr_r, ckeLive);
    outDrvEn = isRunning(pwr_r, ckeLive);
    ckBufEn = !inSelf(pwr_r);
    odtBufEn = !inSelf(pwr_r);
    termEn = {ddr2_ctl_pkg::TERM_W{odtOn_r}};
    dqOut = dq_r;
    dqOutStrobe = dqs_r;
    cmdCode = cmdCode_r;
    cmdValid = cmdValid_r;
    cmdBank = cmdBank_r;
    pwrState = pwr_r;
  end

  // Assertions
  sleep_hold_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (pwr_r != ddr2_ctl_pkg::ST_ACTIVE) |-> !intClkEn && !outDrvEn)
    else $error("clocks run while asleep");
  self_bufs_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (pwr_r == ddr2_ctl_pkg::ST_SELF) |-> !ckBufEn && !odtBufEn && !inBufEn)
    else $error("buffers on in self refresh");
  pd_bufs_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (pwr_r == ddr2_ctl_pkg::ST_PRE_PD) |-> ckBufEn && odtBufEn && !inBufEn)
    else $error("power-down buffer mix wrong");
  act_pd_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (pwr_r == ddr2_ctl_pkg::ST_ACTIVE && ckRise && !ckeS && openRows_r != 4'h0)
    |=> pwr_r == ddr2_ctl_pkg::ST_ACT_PD)
    else $error("active power-down not entered");
  pd_sync_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (pwr_r == ddr2_ctl_pkg::ST_ACTIVE && !ckRise) |=> pwr_r == ddr2_ctl_pkg::ST_ACTIVE)
    else $error("power-down entry off clock edge");
  self_exit_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (pwr_r == ddr2_ctl_pkg::ST_SELF && ckeS) |=> pwr_r == ddr2_ctl_pkg::ST_ACTIVE)
    else $error("self refresh exit late");
  cs_mask_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (ckRise && csS) |=> !cmdValid)
    else $error("deselected command taken");
  odt_off_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (ckRise && odtDisabled) |=> termEn == '0)
    else $error("termination on while disabled");
  rd_edge_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (intClkEn && ckFall) |=> dqOut == $past(rdDataFall) && !dqOutStrobe)
    else $error("falling half not driven");
  cmd_cap_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    !ckRise |=> !cmdValid)
    else $error("command off rising edge");

  // Command capture
  cmd_take_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (ckRise && intClkEn && !csS) |=> cmdValid)
    else $error("selected command dropped");
  code_cap_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (ckRise && intClkEn) |=> cmdCode == {1'b0, $past(rasS), $past(casS), $past(weS)})
    else $error("command code not captured");
  bank_cap_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (ckRise && intClkEn) |=> cmdBank == $past(baS))
    else $error("bank not captured");
  code_hold_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    !(ckRise && intClkEn) |=> $stable(cmdCode) && $stable(cmdBank))
    else $error("command fields moved off capture");
  cmd_one_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    cmdValid |=> !cmdValid)
    else $error("command pulse too long");
  dec_nop_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    csS |-> cmdKind == ddr2_ctl_pkg::CD_NOP)
    else $error("deselected code decoded");

  // Read data and enables
  rd_rise_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (intClkEn && ckRise) |=> dqOut == $past(rdDataRise) && dqOutStrobe)
    else $error("rising half not driven");
  dq_hold_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    !(ckRise || ckFall) |=> $stable(dqOut) && $stable(dqOutStrobe))
    else $error("read data moved off crossing");
  rd_stop_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    !intClkEn |=> $stable(dqOut))
    else $error("read data moved while stopped");
  run_en_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (pwr_r == ddr2_ctl_pkg::ST_ACTIVE && ckeS) |-> intClkEn && inBufEn && outDrvEn)
    else $error("enables off while running");
  cke_low_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    !ckeS |-> !intClkEn && !inBufEn && !outDrvEn)
    else $error("enables on with clock enable low");

  // Power states
  pre_pd_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (pwr_r == ddr2_ctl_pkg::ST_ACTIVE && ckRise && !ckeS && openRows_r == 4'h0
    && !refreshReq) |=> pwr_r == ddr2_ctl_pkg::ST_PRE_PD)
    else $error("precharge power-down not entered");
  self_entry_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (pwr_r == ddr2_ctl_pkg::ST_ACTIVE && ckRise && !ckeS && openRows_r == 4'h0
    && refreshReq) |=> pwr_r == ddr2_ctl_pkg::ST_SELF)
    else $error("self refresh not entered");
  row_open_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (ckRise && intClkEn && cmdKind == ddr2_ctl_pkg::CD_ACT) |=> openRows_r[$past(baS)])
    else $error("row not marked open");
  row_close_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (ckRise && intClkEn && cmdKind == ddr2_ctl_pkg::CD_PRE) |=> !openRows_r[$past(baS)])
    else $error("row not marked closed");
  pd_exit_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (inPowerDown(pwr_r) && ckRise && ckeS) |=> pwr_r == ddr2_ctl_pkg::ST_ACTIVE)
    else $error("power-down exit missed");
  pd_stay_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (inPowerDown(pwr_r) && !ckRise) |=> $stable(pwr_r))
    else $error("power-down left off clock edge");
  pd_nocmd_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (pwr_r != ddr2_ctl_pkg::ST_ACTIVE) |=> !cmdValid)
    else $error("command taken while asleep");
  pd_clk_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    !inSelf(pwr_r) |-> ckBufEn && odtBufEn)
    else $error("clock or termination buffer off");
  self_stay_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (pwr_r == ddr2_ctl_pkg::ST_SELF && !ckeS) |=> pwr_r == ddr2_ctl_pkg::ST_SELF)
    else $error("self refresh left early");

  // Termination and coverage
  term_freeze_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (pwr_r == ddr2_ctl_pkg::ST_SELF && !odtDisabled) |=> $stable(termEn))
    else $error("termination moved in self refresh");
  term_on_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (ckRise && !inSelf(pwr_r) && odtS && !odtDisabled) |=> &termEn)
    else $error("termination not switched on");
  term_off_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (ckRise && !inSelf(pwr_r) && !odtS) |=> termEn == '0)
    else $error("termination not switched off");
  term_all_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (termEn == '0) || (&termEn))
    else $error("termination pins split");
  cov_selfref_c: cover property (@(posedge clk_sys) disable iff (!rst_n)
    pwr_r == ddr2_ctl_pkg::ST_SELF ##1 pwr_r == ddr2_ctl_pkg::ST_ACTIVE);
  cov_actpd_c: cover property (@(posedge clk_sys) disable iff (!rst_n)
    pwr_r == ddr2_ctl_pkg::ST_ACT_PD);
  cov_cmd_c: cover property (@(posedge clk_sys) disable iff (!rst_n) cmdValid);
  cov_term_c: cover property (@(posedge clk_sys) disable iff (!rst_n) termEn[0]);
  cov_prepd_c: cover property (@(posedge clk_sys) disable iff (!rst_n)
    pwr_r == ddr2_ctl_pkg::ST_PRE_PD);
endmodule : ddr2_control_input_stage

// ### verif/ddr2_ctl_model.sv
// Controller model driving clock and command pins
`timescale 1ns/1ps
module ddr2_ctl_model (
  output logic ck,
  output logic cke,
  output logic csN,
  output logic rasN,
  output logic casN,
  output logic weN,
  output logic [1:0] bankAddr,
  output logic odt
);
  logic ckRun = 1'b1;
  // Idle pins: clock low, enabled, deselected, strobes high
  initial begin
    ck = 1'b0;
    cke = 1'b1;
    csN = 1'b1;
    rasN = 1'b1;
    casN = 1'b1;
    weN = 1'b1;
    bankAddr = 2'h0;
    odt = 1'b0;
  end
  // Odd phase offset keeps ck edges off the system clock edges
  initial begin
    #7;
    forever #160 ck = ckRun ? ~ck : 1'b0;
  end
  // Pins change after the fall and hold through the sampling rise
  task issue(input logic [3:0] c, input logic [1:0] b);
    @(negedge ck);
    {csN, rasN, casN, weN} = c;
    bankAddr = b;
    @(negedge ck);
    // Deselected pins go inverted, not left at the old value
    csN = 1'b1;
    {rasN, casN, weN} = ~c[2:0];
    bankAddr = ~b;
  endtask : issue
  // Only between accesses, never in a transfer
  task setCke(input logic v);
    @(negedge ck);
    cke = v;
  endtask : setCke
  task setOdt(input logic v);
    @(negedge ck);
    odt = v;
  endtask : setOdt
  task ckHold(input logic stop);
    ckRun = !stop;
  endtask : ckHold
  // Self refresh exit with the clock stopped
  task ckeAsync();
    cke = 1'b1;
  endtask : ckeAsync
endmodule : ddr2_ctl_model

// ### verif/tb.sv
// Self-checking bench for the control-input stage
`timescale 1ns/1ps
module tb;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic ck, cke, csN, rasN, casN, weN, odt;
  logic [1:0] bankAddr, cmdBank, lastBank;
  logic odtDisabled;
  logic refreshReq;
  logic [15:0] rdDataRise;
  logic [15:0] rdDataFall;
  logic [15:0] dqOut;
  logic dqOutStrobe, cmdValid, intClkEn, inBufEn, outDrvEn, ckBufEn, odtBufEn;
  logic [3:0] cmdCode, lastCode;
  logic [21:0] termEn;
  logic [4:0] ens;
  ddr2_ctl_pkg::pwr_t pwrState;
  int err_count = 0;
  int tests_run = 0;
  int validCnt = 0;
  assign ens = {intClkEn, inBufEn, outDrvEn, ckBufEn, odtBufEn};
  always #20 clk_sys = ~clk_sys;
  ddr2_ctl_model ddr2_ctl_model_inst (.ck, .cke, .csN, .rasN, .casN, .weN,
    .bankAddr, .odt);
  ddr2_control_input_stage ddr2_control_input_stage_inst (.clk_sys, .rst_n,
    .ck, .cke, .csN, .rasN, .casN, .weN, .bankAddr, .odt, .odtDisabled,
    .refreshReq, .rdDataRise, .rdDataFall, .dqOut, .dqOutStrobe, .cmdCode,
    .cmdValid, .cmdBank, .intClkEn, .inBufEn, .outDrvEn, .ckBufEn, .odtBufEn,
    .termEn, .pwrState);
  // One-cycle pulse, latched mid-cycle, away from its launching edge
  always @(negedge clk_sys) begin
    if (cmdValid === 1'b1) begin
      validCnt <= validCnt + 1;
      lastCode <= cmdCode;
      lastBank <= cmdBank;
    end
  end
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task end_sim();
    $display("Checks %0d errors %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : end_sim
  // Waits for the next change of ck to lvl, then lets the sync chain settle
  task waitCk(input logic lvl);
    int i;
    i = 0;
    while (ck !== ~lvl && i < 40) begin
      @(negedge clk_sys);
      i++;
    end
    while (ck !== lvl && i < 40) begin
      @(negedge clk_sys);
      i++;
    end
    if (i >= 40) begin
      chk("ck edge", 32'h1, 32'h0);
      end_sim();
    end else begin
      repeat (5) @(negedge clk_sys);
    end
  endtask : waitCk
  task t_cmd();
    int v;
    for (int i = 7; i >= 0; i--) begin
      v = validCnt;
      ddr2_ctl_model_inst.issue(i[3:0], 2'h2);
      repeat (5) @(negedge clk_sys);
      chk("cmd count", v + 1, validCnt);
      chk("cmdCode", i, lastCode);
      chk("cmdBank", 2'h2, lastBank);
    end
    v = validCnt;
    ddr2_ctl_model_inst.issue(4'hB, 2'h0);
    repeat (5) @(negedge clk_sys);
    chk("masked count", v, validCnt);
  endtask : t_cmd
  task t_read();
    for (int k = 0; k < 2; k++) begin
      rdDataRise = k[0] ? 16'h5A3C : 16'hA5C3;
      rdDataFall = k[0] ? 16'hC3A5 : 16'h3C5A;
      waitCk(1'b1);
      chk("dqOut rise", rdDataRise, dqOut);
      chk("strobe rise", 1'b1, dqOutStrobe);
      waitCk(1'b0);
      chk("dqOut fall", rdDataFall, dqOut);
      chk("strobe fall", 1'b0, dqOutStrobe);
    end
  endtask : t_read
  task t_power();
    int v;
    ddr2_ctl_model_inst.issue(4'h3, 2'h1);
    ddr2_ctl_model_inst.setCke(1'b0);
    waitCk(1'b1);
    chk("act pd", ddr2_ctl_pkg::ST_ACT_PD, pwrState);
    chk("pd enables", 5'h03, ens);
    v = validCnt;
    ddr2_ctl_model_inst.issue(4'h5, 2'h1);
    waitCk(1'b1);
    chk("pd refused", v, validCnt);
    ddr2_ctl_model_inst.setCke(1'b1);
    waitCk(1'b1);
    chk("awake", ddr2_ctl_pkg::ST_ACTIVE, pwrState);
    chk("awake enables", 5'h1F, ens);
    ddr2_ctl_model_inst.issue(4'h2, 2'h1);
    ddr2_ctl_model_inst.setCke(1'b0);
    waitCk(1'b1);
    chk("pre pd", ddr2_ctl_pkg::ST_PRE_PD, pwrState);
    ddr2_ctl_model_inst.setCke(1'b1);
    @(negedge clk_sys);
    refreshReq = 1'b1;
    ddr2_ctl_model_inst.setCke(1'b0);
    waitCk(1'b1);
    chk("self", ddr2_ctl_pkg::ST_SELF, pwrState);
    chk("self enables", 5'h00, ens);
    // Clock stopped: exit must not depend on it
    ddr2_ctl_model_inst.ckHold(1'b1);
    repeat (10) @(negedge clk_sys);
    ddr2_ctl_model_inst.ckeAsync();
    repeat (3) @(negedge clk_sys);
    chk("self exit", ddr2_ctl_pkg::ST_ACTIVE, pwrState);
    refreshReq = 1'b0;
    ddr2_ctl_model_inst.ckHold(1'b0);
  endtask : t_power
  task t_odt();
    ddr2_ctl_model_inst.setOdt(1'b1);
    waitCk(1'b1);
    chk("term on", 22'h3FFFFF, termEn);
    ddr2_ctl_model_inst.setOdt(1'b0);
    waitCk(1'b1);
    chk("term off", 22'h000000, termEn);
    odtDisabled = 1'b1;
    ddr2_ctl_model_inst.setOdt(1'b1);
    waitCk(1'b1);
    chk("term ignored", 22'h000000, termEn);
  endtask : t_odt
  initial begin
    odtDisabled = 1'b0;
    refreshReq = 1'b0;
    rdDataRise = 16'h0000;
    rdDataFall = 16'h0000;
    repeat (3) @(negedge clk_sys);
    rst_n = 1'b1;
    t_cmd();
    t_read();
    t_power();
    t_odt();
    end_sim();
  end
  initial begin
    #2000000;
    err_count++;
    end_sim();
  end
endmodule : tb
